/* i2c_master_model.sv */
// bus master model: drives the clock line and an open-drain data line
module i2c_master_model (
   input  wire logic clock_in,    // bench clock
   input  wire logic sda_in,      // resolved data line
   output logic      scl_out,     // bus clock, stands high between frames
   output logic      sda_drv_out  // 0 pulls data low, 1 releases
);
   timeunit 1ns;
   timeprecision 1ns;
   event       byte_ev;  // a whole read byte has arrived
   event       ack_ev;   // an acknowledge slot was sampled
   logic [7:0] rx_q;     // last byte read
   logic       ack_q;    // last acknowledge level
   initial begin
      scl_out = 1'b1;
      sda_drv_out = 1'b1;
   end
   // quarter of a bus clock cycle, keeps half periods at eight clocks
   task automatic q();
      repeat (4) @(negedge clock_in);
   endtask : q
   // one bit slot; data moves mid-low so it never races the clock edge
   task automatic bit_io(input logic b, output logic s);
      q();
      sda_drv_out = b;
      q();
      scl_out = 1'b1;
      s = sda_in;  // taken at the rise, the strictest moment
      q();
      q();
      scl_out = 1'b0;
   endtask : bit_io
   // start and repeated start share one shape
   task automatic start();
      sda_drv_out = 1'b1;
      q();
      scl_out = 1'b1;
      q();
      q();
      sda_drv_out = 1'b0;
      q();
      q();
      scl_out = 1'b0;
   endtask : start
   task automatic stop();
      q();
      sda_drv_out = 1'b0;
      q();
      scl_out = 1'b1;
      q();
      q();
      sda_drv_out = 1'b1;
      q();
   endtask : stop
   task automatic wbyte(input logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(v[i], s);
      bit_io(1'b1, ack_q);
      ->ack_ev;
   endtask : wbyte
   task automatic rbyte(input logic last);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, rx_q[i]);
      ->byte_ev;
      bit_io(last, s);
   endtask : rbyte
endmodule : i2c_master_model

/* i2c_rd_pkg.sv */
// types for the two-wire slave read path
package i2c_rd_pkg;
   // one-hot framing states
   typedef enum logic [4:0] {
      ST_IDLE = 5'b0_0001,   // waiting for start
      ST_ADDR = 5'b0_0010,   // shifting in address byte
      ST_RECV = 5'b0_0100,   // shifting in write byte
      ST_SEND = 5'b0_1000,   // shifting out read byte
      ST_MACK = 5'b1_0000    // sampling master acknowledge
   } frame_state_t;
   // synchronised bus lines with edge flags
   typedef struct packed {
      logic scl;     // filtered clock level
      logic sda;     // filtered data level
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } bus_view_t;
endpackage : i2c_rd_pkg

/* i2c_rd_regs.svh */
// constants for the two-wire slave read path
`ifndef I2C_RD_REGS_SVH
`define I2C_RD_REGS_SVH
`define ADDR_FIXED_BITS   5'b1_1110
`define REG_TOP_INDEX     8'h0B
`define REG_COUNT         12
`define REG_ZERO_INDEX    8'h00
`define BITS_PER_BYTE     4'h8
`endif

/* i2c_slave_read.sv */
// two-wire slave: address match, pointer handling and read-back
// How it works
// - ack own address on ninth pulse
// - plain start plus read clears pointer
// - data bit stable before clock rises
// - pointer advances after each read byte
// - read after stop restarts at zero
// - indexed register returned before increment
// - pointer saturates at register eleven
// - address 11110 plus two select pins
// - write byte after address loads pointer
`include "i2c_rd_regs.svh"
module i2c_slave_read
   import i2c_rd_pkg::*;
#(
   parameter int NREG = `REG_COUNT   // registers in the bank
) (
   input  wire logic            clock_in,            // 20 MHz clock
   input  wire logic            rst_in,              // sync reset, high
   input  wire logic            scl_in,              // bus clock pin
   input  wire logic            sda_in,              // bus data pin level
   output logic                 sda_out,             // data drive value
   output logic                 sda_oe_n_out,        // low while pulling
   input  wire logic            addr_select_hi_pin,  // address bit 1
   input  wire logic            addr_select_lo_pin,  // address bit 0
   input  wire logic [NREG*8-1:0] reg_bank_in,       // register contents
   output logic [7:0]           pointer_out,         // register pointer
   output logic                 busy_out             // inside a frame
);
   // ************************************************
   // pin synchronisers and edge detection
   // ************************************************
   logic [1:0] scl_sync_q;   // two-flop chain for clock pin
   logic [1:0] sda_sync_q;   // two-flop chain for data pin
   logic       scl_prev_q;   // previous synced clock
   logic       sda_prev_q;   // previous synced data
   logic [1:0] sel_hi_sync_q; // two-flop chain, select pin high
   logic [1:0] sel_lo_sync_q; // two-flop chain, select pin low
   bus_view_t  bus;          // derived bus events

   // first flop feeds only the second
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         scl_sync_q <= 2'b11;
         sda_sync_q <= 2'b11;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         sel_hi_sync_q <= 2'b00;
         sel_lo_sync_q <= 2'b00;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_in};
         sda_sync_q <= {sda_sync_q[0], sda_in};
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
         sel_hi_sync_q <= {sel_hi_sync_q[0], addr_select_hi_pin};
         sel_lo_sync_q <= {sel_lo_sync_q[0], addr_select_lo_pin};
      end
   end

   // events seen from the second flop only
   always_comb begin
      bus.scl      = scl_sync_q[1];
      bus.sda      = sda_sync_q[1];
      bus.scl_rise = scl_sync_q[1] & ~scl_prev_q;
      bus.scl_fall = ~scl_sync_q[1] & scl_prev_q;
      bus.start    = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
      bus.stop     = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
   end

   // ************************************************
   // framing state machine
   // ************************************************
   frame_state_t state_q;     // current framing state
   logic [3:0]   bit_cnt_q;   // bits done in current byte
   logic [7:0]   shift_q;     // in or out shift register
   logic         ack_q;       // device pulls data low
   logic         rd_q;        // current address byte was a read
   logic         ptr_set_q;   // pointer preset since last stop or plain start
   logic         first_q;     // next write byte is the pointer
   logic [7:0]   ptr_q;       // register pointer
   logic [6:0]   own_addr;    // this device's bus address

   // own address from pins
   // select pins are static but unclocked, so only synced copies count
   assign own_addr = {`ADDR_FIXED_BITS, sel_hi_sync_q[1],
                      sel_lo_sync_q[1]};

   // read a bank byte, clamped to the top register
   function automatic logic [7:0] bank_byte(input logic [7:0] idx);
      logic [7:0] k;
      k = (idx > `REG_TOP_INDEX) ? `REG_TOP_INDEX : idx;
      bank_byte = reg_bank_in[k*8 +: 8];
   endfunction : bank_byte

   // saturating increment
   function automatic logic [7:0] ptr_next(input logic [7:0] p);
      ptr_next = (p >= `REG_TOP_INDEX) ? `REG_TOP_INDEX : p + 8'h01;
   endfunction : ptr_next

   // bit counter runs 0..7 data, 8 = ack slot
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_q   <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q   <= 8'h00;
         ack_q     <= 1'b0;
         rd_q      <= 1'b0;
         ptr_set_q <= 1'b0;
         first_q   <= 1'b0;
         ptr_q     <= `REG_ZERO_INDEX;
      end else if (bus.stop) begin
         state_q   <= ST_IDLE;
         ack_q     <= 1'b0;
         ptr_set_q <= 1'b0;
      end else if (bus.start) begin
         // repeated start keeps a preset, plain start does not
         state_q   <= ST_ADDR;
         // the fall closing the start is no bit: wraps to zero there
         bit_cnt_q <= 4'hf;
         ack_q     <= 1'b0;
         if (state_q == ST_IDLE)
            ptr_set_q <= 1'b0;
      end else if (bus.scl_rise) begin
         // sample data or acknowledge on rising edge
         case (state_q)
            ST_ADDR, ST_RECV: begin
               if (bit_cnt_q < `BITS_PER_BYTE)
                  shift_q <= {shift_q[6:0], bus.sda};
            end
            ST_MACK: begin
               // nack ends our part of the frame
               if (bus.sda)
                  state_q <= ST_IDLE;
            end
            default: begin
            end
         endcase
      end else if (bus.scl_fall) begin
         case (state_q)
            ST_ADDR: begin
               if (bit_cnt_q == 4'h7) begin
                  bit_cnt_q <= 4'h8;
                  // ack own address in ninth pulse
                  if (shift_q[7:1] == own_addr) begin
                     ack_q <= 1'b1;
                     rd_q  <= shift_q[0];
                     first_q <= ~shift_q[0];
                     if (shift_q[0] && !ptr_set_q)
                        ptr_q <= `REG_ZERO_INDEX;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end else if (bit_cnt_q == 4'h8) begin
                  ack_q     <= 1'b0;
                  bit_cnt_q <= 4'h0;
                  if (rd_q) begin
                     state_q <= ST_SEND;
                     shift_q <= bank_byte(ptr_q);
                  end else begin
                     state_q <= ST_RECV;
                  end
               end else begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end
            end
            ST_RECV: begin
               if (bit_cnt_q == 4'h7) begin
                  bit_cnt_q <= 4'h8;
                  ack_q     <= 1'b1;
                  if (first_q) begin
                     ptr_q     <= shift_q;
                     ptr_set_q <= 1'b1;
                     first_q   <= 1'b0;
                  end else begin
                     ptr_q <= ptr_next(ptr_q);
                  end
               end else if (bit_cnt_q == 4'h8) begin
                  ack_q     <= 1'b0;
                  bit_cnt_q <= 4'h0;
               end else begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end
            end
            ST_SEND: begin
               // shift on falling edge so bit is stable at rise
               if (bit_cnt_q == 4'h7) begin
                  bit_cnt_q <= 4'h8;
                  state_q   <= ST_MACK;
                  // advance after the byte goes out
                  ptr_q     <= ptr_next(ptr_q);
               end else begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  shift_q   <= {shift_q[6:0], 1'b1};
               end
            end
            ST_MACK: begin
               bit_cnt_q <= 4'h0;
               state_q   <= ST_SEND;
               shift_q   <= bank_byte(ptr_q);
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ************************************************
   // open-drain drive, registered
   // ************************************************
   logic drive_low_q;   // pull data line low
   always_ff @(posedge clock_in) begin
      if (rst_in)
         drive_low_q <= 1'b0;
      else
         drive_low_q <= ack_q | ((state_q == ST_SEND) & ~shift_q[7]);
   end

   assign sda_out      = 1'b0;
   assign sda_oe_n_out = ~drive_low_q;
   assign pointer_out  = ptr_q;
   assign busy_out     = (state_q != ST_IDLE);

   // ************************************************
   // assertions
   // ************************************************
   // pointer above top register only around a preset
   ptr_saturate_a: assert property (@(posedge clock_in) disable iff (rst_in)
      ptr_q <= `REG_TOP_INDEX || $past(ptr_set_q) || ptr_set_q)
      else $error("pointer beyond top register");
   nack_release_a: assert property (@(posedge clock_in) disable iff (rst_in)
      (state_q == ST_MACK && bus.scl_rise && bus.sda && !bus.stop
       && !bus.start) |-> ##2 sda_oe_n_out)
      else $error("data line held after nack");
   // send bit unchanged on the clock after a rise in send
   bit_stable_a: assert property (@(posedge clock_in) disable iff (rst_in)
      (state_q == ST_SEND && bus.scl_rise) |=> $stable(shift_q[7]))
      else $error("send bit moved at clock rise");
   // own address byte ends on a fall
   sequence addr_match_s;
      state_q == ST_ADDR && bus.scl_fall && bit_cnt_q == 4'h7
      && shift_q[7:1] == own_addr;
   endsequence
   // that byte asks for a read with no preset
   sequence plain_read_s;
      addr_match_s ##0 (shift_q[0] && !ptr_set_q);
   endsequence
   // data line pulled low for the ninth pulse
   addr_ack_a: assert property (@(posedge clock_in) disable iff (rst_in)
      addr_match_s |-> ##2 !sda_oe_n_out)
      else $error("own address not acknowledged");
   // pointer cleared for a plain read
   ptr_clear_a: assert property (@(posedge clock_in) disable iff (rst_in)
      plain_read_s |=> ptr_q == `REG_ZERO_INDEX)
      else $error("pointer not cleared for plain read");
   // pointer moves on once the byte is out
   ptr_advance_a: assert property (@(posedge clock_in) disable iff (rst_in)
      (state_q == ST_SEND && bus.scl_fall && bit_cnt_q == 4'h7)
      |=> (ptr_q == $past(ptr_q) + 8'h01 || ptr_q == `REG_TOP_INDEX))
      else $error("pointer not advanced after read byte");
   // stop ends the frame and drops any preset
   stop_idle_a: assert property (@(posedge clock_in) disable iff (rst_in)
      bus.stop |=> !busy_out && !ptr_set_q)
      else $error("stop left frame or preset active");
endmodule : i2c_slave_read

/* tb.sv */
// testbench: master model reads the bank, queued notes check the bytes
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock_in = 1'b0;  // 20 MHz
   logic        rst_in   = 1'b1;  // held for 16 cycles
   logic        hi_pin, lo_pin;   // address select pins
   logic [95:0] bank;             // register contents
   logic        sda_out, sda_oe_n_out, busy_out, scl, m_sda;
   logic [7:0]  pointer_out;
   logic [7:0]  exp_q[$];         // expected read bytes
   logic        exp_a[$];         // expected acknowledge levels
   logic [7:0]  idx[3] = '{8'h05, 8'h0B, 8'h20};
   int          failures = 0, check_count = 0;
   int          seed = 32'hc53d_1272;
   wire         sda_bus = m_sda & sda_oe_n_out;  // pull-up wins if released
   always #25 clock_in = ~clock_in;
   i2c_master_model m_u (.clock_in(clock_in), .sda_in(sda_bus),
      .scl_out(scl), .sda_drv_out(m_sda));
   i2c_slave_read dut_u (.clock_in(clock_in), .rst_in(rst_in),
      .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
      .sda_oe_n_out(sda_oe_n_out), .addr_select_hi_pin(hi_pin),
      .addr_select_lo_pin(lo_pin), .reg_bank_in(bank),
      .pointer_out(pointer_out), .busy_out(busy_out));
   task automatic check_byte(string n, logic [7:0] e, logic [7:0] s);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : check_byte
   task automatic check_bit(string n, logic e, logic s);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, s);
      end
   endtask : check_bit
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   // monitors take the oldest note as each result appears
   always @(m_u.byte_ev) check_byte("read", exp_q.pop_front(), m_u.rx_q);
   always @(m_u.ack_ev) check_bit("ack", exp_a.pop_front(), m_u.ack_q);
   task automatic wr(input logic [7:0] v, input logic ok);
      exp_a.push_back(~ok);
      m_u.wbyte(v);
   endtask : wr
   task automatic addr(input logic rw, input logic ok);
      wr({5'b1_1110, hi_pin, lo_pin ^ ~ok, rw}, ok);
   endtask : addr
   // pointer clamps at the top register, no wrap
   task automatic rd(input int p, input int n);
      for (int i = 0; i < n; i++) begin
         exp_q.push_back(bank[8*(p > 11 ? 11 : p) +: 8]);
         p++;
         m_u.rbyte(i == n - 1);
      end
      m_u.stop();
      repeat (8) @(negedge clock_in);
      check_bit("busy", 1'b0, busy_out);
      check_bit("drive value", 1'b0, sda_out);
   endtask : rd
   initial begin
      #3_000_000;
      failures++;
      end_of_test();
   end
   initial begin
      {hi_pin, lo_pin, bank} = '0;
      repeat (16) @(negedge clock_in);
      rst_in = 1'b0;
      repeat (4) @(negedge clock_in);
      for (int k = 0; k < 4; k++) begin
         {hi_pin, lo_pin} = 2'($random(seed));
         bank = {$random(seed), $random(seed), $random(seed)};
         m_u.start();
         addr(1'b1, 1'b1);
         rd(0, 14);
         m_u.start();
         addr(1'b1, 1'b1);
         rd(0, 2);
         foreach (idx[j]) begin
            m_u.start();
            addr(1'b0, 1'b1);
            wr(idx[j], 1'b1);
            m_u.start();
            if (idx[j] < 12) check_byte("pointer", idx[j], pointer_out);
            addr(1'b1, 1'b1);
            rd(idx[j], 3);
         end
         // data bytes after the preset step the pointer up to the top
         m_u.start();
         addr(1'b0, 1'b1);
         wr(8'h0A, 1'b1);
         wr(8'($random(seed)), 1'b1);
         wr(8'($random(seed)), 1'b1);
         m_u.start();
         check_byte("pointer", 8'h0B, pointer_out);
         addr(1'b1, 1'b1);
         rd(11, 2);
         m_u.start();
         addr(1'b1, 1'b0);
         m_u.stop();
         $display("test %0d done", k);
      end
      end_of_test();
   end
endmodule : tb
